// *** hdl/ppm_pkg.sv ***
package ppm_pkg;

	// ************************************************
	// modes of one channel
	// ************************************************
	typedef enum logic [3:0] {
		PPM_UART, PPM_AFIFO, PPM_SFIFO, PPM_ABB, PPM_SBB,
		PPM_SENG, PPM_FSER, PPM_CPU, PPM_HEMU
	} ppm_mode_type;

	// stored configuration codes
	localparam logic [1:0] CFG_UART = 2'h0;
	localparam logic [1:0] CFG_AFIFO = 2'h1;
	localparam logic [1:0] CFG_CPU = 2'h2;
	localparam logic [1:0] CFG_FSER = 2'h3;

	// mode switch command values
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] CMD_ABB = 8'h01;
	localparam logic [7:0] CMD_SENG = 8'h02;
	localparam logic [7:0] CMD_SBB = 8'h04;
	localparam logic [7:0] CMD_HEMU = 8'h08;
	localparam logic [7:0] CMD_SFIFO = 8'h40;

	// ************************************************
	// port register map and status layout
	// ************************************************
	localparam logic ADDR_DATA = 1'h0;
	localparam logic ADDR_STATUS = 1'h1;
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_TX_SPACE = 1;
	localparam int ST_SUSPEND = 2;
	localparam int ST_CONFIGURED = 3;
	localparam logic [3:0] ST_UNUSED = 4'h0;

	// ************************************************
	// reset values and timing
	// ************************************************
	localparam logic [7:0] PORT_IDLE = 8'hFF;
	localparam int CLK_NS = 20;
	localparam int ABB_PERIOD_NS = 80;
	localparam int ABB_PERIOD_CYC = (ABB_PERIOD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] ABB_LAST = 4'(ABB_PERIOD_CYC - 1);
	localparam logic [3:0] ABB_WR_PHASE = 4'(ABB_PERIOD_CYC / 2);

endpackage

// *** hdl/ppm_mode_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppm_mode_ctrl #(
	parameter bit IS_CHAN_B = 1'b0
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// stored configuration
	input wire logic cfg_load_in,
	input wire logic [1:0] cfg_mode_in,
	// runtime commands
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_value_in,
	input wire logic enumerated_in,
	input wire logic partner_afifo_in,
	// result
	output ppm_pkg::ppm_mode_type mode_out
);
	import ppm_pkg::*;

	ppm_mode_type base, next_base, next_mode;
	logic cfg_done, next_cfg_done;

	always_comb begin
		next_base = base;
		next_mode = mode_out;
		next_cfg_done = cfg_done;
		// configuration taken once after reset only
		if (cfg_load_in && !cfg_done) begin
			next_cfg_done = 1'b1;
			unique case (cfg_mode_in)
				CFG_UART: next_base = PPM_UART;
				CFG_AFIFO: next_base = PPM_AFIFO;
				CFG_CPU: next_base = PPM_CPU;
				CFG_FSER: next_base = PPM_FSER;
			endcase
			next_mode = next_base;
		end else if (cmd_valid_in && enumerated_in) begin
			case (cmd_value_in)
				CMD_RESET: next_mode = base;
				CMD_ABB: next_mode = PPM_ABB;
				CMD_SBB: next_mode = PPM_SBB;
				CMD_SENG: next_mode = PPM_SENG;
				CMD_HEMU: next_mode = PPM_HEMU;
				// sync fifo needs both channels already in async fifo
				CMD_SFIFO: if (!IS_CHAN_B && mode_out == PPM_AFIFO && partner_afifo_in) next_mode = PPM_SFIFO;
				default: next_mode = mode_out;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			base <= PPM_UART;
			mode_out <= PPM_UART;
			cfg_done <= 1'b0;
		end else begin
			base <= next_base;
			mode_out <= next_mode;
			cfg_done <= next_cfg_done;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_cmd_abb;
		cmd_valid_in && enumerated_in && !(cfg_load_in && !cfg_done) && cmd_value_in == CMD_ABB |=> mode_out == PPM_ABB;
	endproperty
	a_cmd_abb: assert property (p_cmd_abb) else $error("abb command not taken");

	property p_cmd_sbb;
		cmd_valid_in && enumerated_in && !(cfg_load_in && !cfg_done) && cmd_value_in == CMD_SBB |=> mode_out == PPM_SBB;
	endproperty
	a_cmd_sbb: assert property (p_cmd_sbb) else $error("sbb command not taken");

	property p_reset_uart;
		$rose(rstn_in) |-> mode_out == PPM_UART;
	endproperty
	a_reset_uart: assert property (@(posedge sys_clk_in) p_reset_uart) else $error("not uart after reset");

endmodule
`default_nettype wire

// *** hdl/ppm_sbb_seq.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppm_sbb_seq (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// control
	input wire logic start_in,
	output logic busy_out,
	output logic sample_out,
	output logic drive_out,
	output logic push_out,
	// strobes
	output logic rd_n_out,
	output logic wr_n_out
);

	typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_RD_OFF, S_RD_ON, S_SETUP, S_WR_ON, S_WR_OFF} ppm_seq_type;
	ppm_seq_type state, next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: if (start_in) next_state = S_SAMPLE;
			S_SAMPLE: next_state = S_RD_OFF;
			S_RD_OFF: next_state = S_RD_ON;
			S_RD_ON: next_state = S_SETUP;
			S_SETUP: next_state = S_WR_ON;
			S_WR_ON: next_state = S_WR_OFF;
			S_WR_OFF: next_state = S_IDLE;
		endcase
	end

	// outputs decoded from the next state so they stay pure flops
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			state <= S_IDLE;
			busy_out <= 1'b0;
			sample_out <= 1'b0;
			drive_out <= 1'b0;
			push_out <= 1'b0;
			rd_n_out <= 1'b0;
			wr_n_out <= 1'b1;
		end else begin
			state <= next_state;
			busy_out <= next_state != S_IDLE;
			sample_out <= next_state == S_SAMPLE;
			drive_out <= next_state == S_RD_ON;
			push_out <= next_state == S_WR_OFF;
			rd_n_out <= next_state == S_RD_OFF;
			wr_n_out <= next_state != S_WR_ON;
		end
	end

endmodule
`default_nettype wire

// *** hdl/ppm_channel_port.sv ***
// Function
// - cpu target mode: select high ignores strobes; data pipe read pops rx, write pushes tx
// - status address: read returns status byte, write sends immediately
// - status bits 0..3: rx available, tx space, suspend, configured
// - cpu target mode comes from stored configuration at reset
// - async bit-bang holds last received byte on the port
// - async bit-bang read and write strobes pulse continuously
// - sync bit-bang changes pins only on a received byte, read strobe marks it
// - sync bit-bang samples pins only as a result of a port write
// - mode command value 1 selects async bit-bang
// - mode command value 4 selects sync bit-bang
// - sync cycle: sample, read strobe off, on with data, setup, write pulse
// - reset gives serial mode, stored configuration then picks the mode
// - after enumeration commands select bit-bang or serial engine
// - sync fifo: channel A takes B's buffer, B unavailable
// - unused channel B keeps default pin levels
// - stored-config modes and command modes are kept apart
`timescale 1ns/1ns
`default_nettype none
module ppm_channel_port #(
	parameter bit IS_CHAN_B = 1'b0,
	parameter int PORT_W = 8
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// configuration and commands
	input wire logic cfg_load_in,
	input wire logic [1:0] cfg_mode_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_value_in,
	input wire logic enumerated_in,
	// other channel
	input wire logic partner_afifo_in,
	input wire logic partner_sfifo_in,
	// usb receive buffer
	input wire logic rx_valid_in,
	input wire logic [PORT_W-1:0] rx_data_in,
	output logic rx_ready_out,
	// usb transmit buffer
	output logic tx_valid_out,
	output logic [PORT_W-1:0] tx_data_out,
	input wire logic tx_ready_in,
	output logic send_immediate_out,
	// usb state
	input wire logic usb_suspend_in,
	input wire logic usb_configured_in,
	// parallel pins
	input wire logic cs_n_in,
	input wire logic register_select_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [PORT_W-1:0] port_data_bus_in,
	output logic [PORT_W-1:0] port_data_bus_out,
	output logic port_data_bus_oe_out,
	output logic bb_read_strobe_n_out,
	output logic bb_write_strobe_n_out,
	output logic bb_strobe_oe_out,
	output logic rx_full_n_out,
	output logic tx_empty_n_out,
	// mode state
	output ppm_pkg::ppm_mode_type mode_out,
	output logic buffer_merge_out
);
	import ppm_pkg::*;

	// ************************************************
	// mode control and sync bit-bang sequencer
	// ************************************************
	ppm_mode_type mode;
	logic seq_busy, seq_sample, seq_drive, seq_push, seq_rd_n, seq_wr_n, seq_start;

	ppm_mode_ctrl #(.IS_CHAN_B(IS_CHAN_B)) u_mode (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.cfg_load_in(cfg_load_in),
		.cfg_mode_in(cfg_mode_in),
		.cmd_valid_in(cmd_valid_in),
		.cmd_value_in(cmd_value_in),
		.enumerated_in(enumerated_in),
		.partner_afifo_in(partner_afifo_in),
		.mode_out(mode)
	);

	ppm_sbb_seq u_seq (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.start_in(seq_start),
		.busy_out(seq_busy),
		.sample_out(seq_sample),
		.drive_out(seq_drive),
		.push_out(seq_push),
		.rd_n_out(seq_rd_n),
		.wr_n_out(seq_wr_n)
	);

	// ************************************************
	// state
	// ************************************************
	logic [PORT_W-1:0] next_port_data, pend, next_pend, smp, next_smp, next_tx_data;
	logic next_oe, next_bbr_n, next_bbw_n, next_bb_oe, next_rxf_n, next_txe_n;
	logic next_rx_ready, next_tx_valid, next_flush, next_merge;
	logic rd_d, wr_d, used, next_used;
	logic [3:0] abb_cnt, next_abb_cnt;
	ppm_mode_type next_mode_out;

	logic rd_fall, wr_fall, unavail, pipe_sel, a0, tx_space;
	logic [7:0] status;

	assign rd_fall = rd_d && !rd_n_in;
	assign wr_fall = wr_d && !wr_n_in;
	// channel A in sync fifo owns this channel's buffer
	assign unavail = IS_CHAN_B && partner_sfifo_in;
	assign tx_space = tx_ready_in && !tx_valid_out;
	// taken live at the strobe edge, high nibble zero
	assign status = {ST_UNUSED, usb_configured_in, usb_suspend_in, tx_space, rx_valid_in};
	assign pipe_sel = (mode == PPM_CPU) ? !cs_n_in : 1'b1;
	assign a0 = (mode == PPM_CPU) ? register_select_in : ADDR_DATA;
	// back-pressure: no new sync cycle while a sample waits for usb
	assign seq_start = (mode == PPM_SBB) && !unavail && rx_valid_in && !seq_busy && !rx_ready_out && !tx_valid_out;

	always_comb begin
		next_port_data = port_data_bus_out;
		next_oe = port_data_bus_oe_out;
		next_bbr_n = 1'b1;
		next_bbw_n = 1'b1;
		next_bb_oe = 1'b0;
		next_rxf_n = rx_full_n_out;
		next_txe_n = tx_empty_n_out;
		next_rx_ready = 1'b0;
		next_tx_valid = tx_valid_out && !tx_ready_in;
		next_tx_data = tx_data_out;
		next_flush = 1'b0;
		next_used = used;
		next_pend = pend;
		next_smp = smp;
		next_abb_cnt = 4'h0;
		next_mode_out = mode;
		next_merge = !IS_CHAN_B && mode == PPM_SFIFO;
		if (unavail) begin
			if (!used) begin
				next_port_data = PORT_IDLE;
				next_oe = 1'b1;
				next_txe_n = 1'b0;
				next_rxf_n = 1'b1;
			end else begin
				// pins freeze where the last transfer left them
				next_bbr_n = bb_read_strobe_n_out;
				next_bbw_n = bb_write_strobe_n_out;
				next_bb_oe = bb_strobe_oe_out;
			end
		end else begin
			unique case (mode)
				PPM_CPU, PPM_AFIFO, PPM_SFIFO: begin
					if (rd_n_in)
						next_oe = 1'b0;
					// select high masks both strobes in cpu target mode only; fifo modes ignore select
					if (pipe_sel && rd_fall) begin
						if (a0 == ADDR_STATUS) begin
							next_port_data = status;
							next_oe = 1'b1;
						end else if (rx_valid_in) begin
							next_port_data = rx_data_in;
							next_oe = 1'b1;
							next_rx_ready = 1'b1;
							next_used = 1'b1;
						end
					end
					if (pipe_sel && wr_fall) begin
						if (a0 == ADDR_STATUS) begin
							next_flush = 1'b1;
						end else if (!tx_valid_out) begin
							next_tx_valid = 1'b1;
							next_tx_data = port_data_bus_in;
							next_used = 1'b1;
						end
					end
					next_rxf_n = !(rx_valid_in && !next_rx_ready);
					next_txe_n = next_tx_valid || !tx_ready_in;
				end
				PPM_ABB: begin
					next_abb_cnt = (abb_cnt == ABB_LAST) ? 4'h0 : abb_cnt + 4'h1;
					next_bb_oe = 1'b1;
					next_bbr_n = abb_cnt != 4'h0;
					next_bbw_n = abb_cnt != ABB_WR_PHASE;
					next_oe = 1'b1;
					// byte stays on the pins until the next one
					if (rx_valid_in && !rx_ready_out) begin
						next_port_data = rx_data_in;
						next_rx_ready = 1'b1;
						next_used = 1'b1;
					end
					if (abb_cnt == ABB_WR_PHASE && !tx_valid_out) begin
						next_tx_valid = 1'b1;
						next_tx_data = port_data_bus_in;
					end
				end
				PPM_SBB: begin
					next_bb_oe = 1'b1;
					next_bbr_n = seq_rd_n;
					next_bbw_n = seq_wr_n;
					next_oe = 1'b1;
					if (seq_start) begin
						next_pend = rx_data_in;
						next_rx_ready = 1'b1;
						next_used = 1'b1;
					end
					if (seq_sample)
						next_smp = port_data_bus_in;
					if (seq_drive)
						next_port_data = pend;
					if (seq_push) begin
						next_tx_valid = 1'b1;
						next_tx_data = smp;
					end
				end
				default: begin
					next_oe = 1'b0;
					next_rxf_n = 1'b1;
					next_txe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			port_data_bus_out <= PORT_IDLE;
			port_data_bus_oe_out <= 1'b0;
			bb_read_strobe_n_out <= 1'b1;
			bb_write_strobe_n_out <= 1'b1;
			bb_strobe_oe_out <= 1'b0;
			rx_full_n_out <= 1'b1;
			tx_empty_n_out <= 1'b1;
			rx_ready_out <= 1'b0;
			tx_valid_out <= 1'b0;
			tx_data_out <= '0;
			send_immediate_out <= 1'b0;
			buffer_merge_out <= 1'b0;
			mode_out <= PPM_UART;
			rd_d <= 1'b1;
			wr_d <= 1'b1;
			used <= 1'b0;
			pend <= '0;
			smp <= '0;
			abb_cnt <= 4'h0;
		end else begin
			port_data_bus_out <= next_port_data;
			port_data_bus_oe_out <= next_oe;
			bb_read_strobe_n_out <= next_bbr_n;
			bb_write_strobe_n_out <= next_bbw_n;
			bb_strobe_oe_out <= next_bb_oe;
			rx_full_n_out <= next_rxf_n;
			tx_empty_n_out <= next_txe_n;
			rx_ready_out <= next_rx_ready;
			tx_valid_out <= next_tx_valid;
			tx_data_out <= next_tx_data;
			send_immediate_out <= next_flush;
			buffer_merge_out <= next_merge;
			mode_out <= next_mode_out;
			rd_d <= rd_n_in;
			wr_d <= wr_n_in;
			used <= next_used;
			pend <= next_pend;
			smp <= next_smp;
			abb_cnt <= next_abb_cnt;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	logic cpu_live;
	logic [3:0] hi_cnt;
	assign cpu_live = mode == PPM_CPU && !unavail;
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in || mode_out != PPM_ABB || !bb_read_strobe_n_out)
			hi_cnt <= 4'h0;
		else
			hi_cnt <= hi_cnt + 4'h1;
	end

	property p_ignore_cs;
		cpu_live && cs_n_in && (rd_fall || wr_fall) |=> !rx_ready_out && !send_immediate_out;
	endproperty
	a_ignore_cs: assert property (p_ignore_cs) else $error("strobe taken while deselected");

	property p_pop;
		cpu_live && !cs_n_in && !register_select_in && rd_fall && rx_valid_in
			|=> rx_ready_out && port_data_bus_oe_out && port_data_bus_out == $past(rx_data_in);
	endproperty
	a_pop: assert property (p_pop) else $error("data pipe read failed");

	property p_status;
		cpu_live && !cs_n_in && register_select_in && rd_fall |=> !rx_ready_out
			&& port_data_bus_out == {4'h0, $past(usb_configured_in), $past(usb_suspend_in), $past(tx_space), $past(rx_valid_in)};
	endproperty
	a_status: assert property (p_status) else $error("status byte wrong");

	property p_flush;
		cpu_live && !cs_n_in && register_select_in && wr_fall |=> send_immediate_out && !$rose(tx_valid_out);
	endproperty
	a_flush: assert property (p_flush) else $error("send immediate missing");

	property p_abb_hold;
		mode_out == PPM_ABB && $past(mode_out) == PPM_ABB && !rx_ready_out |-> $stable(port_data_bus_out);
	endproperty
	a_abb_hold: assert property (p_abb_hold) else $error("async port byte changed");

	property p_abb_strobe;
		hi_cnt < 4'(ABB_PERIOD_CYC);
	endproperty
	a_abb_strobe: assert property (p_abb_strobe) else $error("async read strobe stopped");

	property p_sbb_order;
		mode_out == PPM_SBB && $rose(bb_read_strobe_n_out) && !unavail |=> !bb_read_strobe_n_out
			&& port_data_bus_out == $past(pend) ##1 bb_write_strobe_n_out ##1 !bb_write_strobe_n_out ##1 bb_write_strobe_n_out;
	endproperty
	a_sbb_order: assert property (p_sbb_order) else $error("sync cycle out of order");

	property p_sbb_push;
		mode_out == PPM_SBB && $past(mode_out) == PPM_SBB && !unavail
			|-> $rose(tx_valid_out) == $rose(bb_write_strobe_n_out);
	endproperty
	a_sbb_push: assert property (p_sbb_push) else $error("sample not tied to write");

	property p_unused_b;
		unavail && !used |=> port_data_bus_out == PORT_IDLE && !tx_empty_n_out && rx_full_n_out && !bb_strobe_oe_out;
	endproperty
	a_unused_b: assert property (p_unused_b) else $error("unused channel pins not default");

	c_pop: cover property (cpu_live && !cs_n_in && !register_select_in && rd_fall && rx_valid_in);
	c_status: cover property (cpu_live && !cs_n_in && register_select_in && rd_fall);
	c_sbb: cover property (mode_out == PPM_SBB && $rose(tx_valid_out));

endmodule
`default_nettype wire

// *** test/ppm_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppm_host_model (
	// clock
	input wire logic sys_clk_in,
	// resolved data pins
	input wire logic [7:0] pin_in,
	// processor side strobes and data
	output logic cs_n_out,
	output logic register_select_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [7:0] data_out
);
	initial begin
		cs_n_out = 1'b1;
		register_select_out = 1'b0;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		data_out = 8'h5A;
	end

	// ********************************
	// one strobe access, driven at falling edges
	// ********************************
	// held for three rising edges so a high sample always separates accesses
	task automatic access(input logic sel_n, input logic a0, input logic wr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		@(negedge sys_clk_in);
		cs_n_out = sel_n;
		register_select_out = a0;
		data_out = wr ? wdata : ~data_out;
		rd_n_out = wr;
		wr_n_out = !wr;
		repeat (3) @(posedge sys_clk_in);
		// upper status bits carry nothing, never looked at
		rdata = a0 ? {4'h0, pin_in[3:0]} : pin_in;
		@(negedge sys_clk_in);
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		cs_n_out = 1'b1;
		// released bus shows the inverse of the last byte
		data_out = ~data_out;
		repeat (2) @(negedge sys_clk_in);
	endtask
endmodule
`default_nettype wire

// *** test/channel_parallel_port_modes_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module channel_parallel_port_modes_bench;
	import ppm_pkg::*;
	// ********************************
	// stimulus, wires, scoreboards
	// ********************************
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cfg_load_in = 1'b0;
	logic [1:0] cfg_mode_in = CFG_CPU;
	logic cmd_valid_in = 1'b0;
	logic [7:0] cmd_value_in = 8'h00;
	logic enumerated_in = 1'b0;
	logic partner_afifo_in = 1'b0;
	logic rx_valid_in = 1'b0;
	logic [7:0] rx_data_in = 8'h00;
	logic tx_ready_in = 1'b0;
	logic usb_suspend_in = 1'b0;
	logic usb_configured_in = 1'b0;
	logic tx_rand = 1'b0;
	logic tx_ignore = 1'b0;
	logic popped = 1'b0;
	wire logic cs_n, a0_sel, rd_n, wr_n, rx_ready, tx_valid, si, dev_oe, rd_s, wr_s, s_oe, rxf_n, txe_n, merge;
	wire logic [7:0] host_d, dev_d, tx_d, port_pin;
	wire ppm_mode_type mode;
	wire logic b_oe, b_soe, b_rxf, b_txe;
	wire logic [7:0] b_d;
	logic [7:0] usb_rx[$];
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int si_count = 0;
	logic [7:0] cmd_tab[5] = '{CMD_SENG, CMD_HEMU, CMD_SBB, CMD_RESET, CMD_ABB};
	ppm_mode_type mode_tab[5] = '{PPM_SENG, PPM_HEMU, PPM_SBB, PPM_CPU, PPM_ABB};
	logic [9:0] sbb_exp = 10'b11_01_01_00_01;

	assign port_pin = dev_oe ? dev_d : host_d;

	initial forever #10 sys_clk_in = ~sys_clk_in;

	ppm_channel_port #(.IS_CHAN_B(1'b0), .PORT_W(8)) u_ppm_channel_port (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cfg_load_in(cfg_load_in), .cfg_mode_in(cfg_mode_in),
		.cmd_valid_in(cmd_valid_in), .cmd_value_in(cmd_value_in), .enumerated_in(enumerated_in),
		.partner_afifo_in(partner_afifo_in), .partner_sfifo_in(1'b0), .rx_valid_in(rx_valid_in),
		.rx_data_in(rx_data_in), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_d),
		.tx_ready_in(tx_ready_in), .send_immediate_out(si), .usb_suspend_in(usb_suspend_in),
		.usb_configured_in(usb_configured_in), .cs_n_in(cs_n), .register_select_in(a0_sel), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .port_data_bus_in(port_pin), .port_data_bus_out(dev_d), .port_data_bus_oe_out(dev_oe),
		.bb_read_strobe_n_out(rd_s), .bb_write_strobe_n_out(wr_s), .bb_strobe_oe_out(s_oe),
		.rx_full_n_out(rxf_n), .tx_empty_n_out(txe_n), .mode_out(mode), .buffer_merge_out(merge));

	ppm_host_model u_ppm_host_model (.sys_clk_in(sys_clk_in), .pin_in(port_pin), .cs_n_out(cs_n),
		.register_select_out(a0_sel), .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(host_d));

	// second channel, never used, gives up its buffer once channel A merges
	ppm_channel_port #(.IS_CHAN_B(1'b1), .PORT_W(8)) u_ppm_channel_port_b (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cfg_load_in(cfg_load_in), .cfg_mode_in(cfg_mode_in),
		.cmd_valid_in(1'b0), .cmd_value_in(8'h00), .enumerated_in(1'b0), .partner_afifo_in(1'b1),
		.partner_sfifo_in(merge), .rx_valid_in(1'b0), .rx_data_in(8'h00), .rx_ready_out(), .tx_valid_out(),
		.tx_data_out(), .tx_ready_in(1'b1), .send_immediate_out(), .usb_suspend_in(1'b0),
		.usb_configured_in(1'b0), .cs_n_in(1'b1), .register_select_in(1'b0), .rd_n_in(1'b1), .wr_n_in(1'b1),
		.port_data_bus_in(8'h00), .port_data_bus_out(b_d), .port_data_bus_oe_out(b_oe),
		.bb_read_strobe_n_out(), .bb_write_strobe_n_out(), .bb_strobe_oe_out(b_soe),
		.rx_full_n_out(b_rxf), .tx_empty_n_out(b_txe), .mode_out(), .buffer_merge_out());

	// ********************************
	// usb side feeder and result monitor
	// ********************************
	// byte leaves only after the edge that consumed it
	always @(negedge sys_clk_in) begin
		if (popped && usb_rx.size() > 0)
			void'(usb_rx.pop_front());
		popped = rx_ready && rx_valid_in;
		rx_valid_in = usb_rx.size() > 0;
		rx_data_in = rx_valid_in ? usb_rx[0] : ~rx_data_in;
		tx_ready_in = tx_rand ? 1'($urandom) : 1'b1;
	end

	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			summarize();
		end
		if (si)
			si_count++;
		if (rx_ready && mode !== PPM_SBB) begin
			if (rxq.size() > 0)
				check("rx_byte", dev_d, rxq.pop_front());
			else
				check("rx_extra_pop", 16'h0001, 16'h0000);
		end
		if (tx_valid && tx_ready_in && !tx_ignore) begin
			if (txq.size() > 0)
				check("tx_byte", tx_d, txq.pop_front());
			else
				check("tx_extra", 16'h0001, 16'h0000);
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wait_mode(input ppm_mode_type m);
		repeat (2) @(posedge sys_clk_in);
		#1;
		check("mode", {12'h000, mode}, {12'h000, m});
	endtask

	task automatic do_reset(input logic [1:0] cfg, input ppm_mode_type m);
		@(negedge sys_clk_in);
		rstn_in = 1'b0;
		repeat (8) @(negedge sys_clk_in);
		check("rst_data", dev_d, PORT_IDLE);
		check("rst_ctl", {dev_oe, rd_s, wr_s, s_oe, rxf_n, txe_n, rx_ready, tx_valid, si}, 9'b011011000);
		check("rst_mode", {12'h000, mode}, {12'h000, PPM_UART});
		rstn_in = 1'b1;
		cfg_load_in = 1'b1;
		cfg_mode_in = cfg;
		@(negedge sys_clk_in);
		cfg_load_in = 1'b0;
		wait_mode(m);
	endtask

	task automatic command(input logic [7:0] v, input ppm_mode_type m);
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b1;
		cmd_value_in = v;
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b0;
		cmd_value_in = 8'($urandom);
		wait_mode(m);
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		int i;
		int n;
		int rd_lo;
		int wr_lo;
		logic [7:0] b;
		logic [7:0] r;
		void'($urandom(32'hCAB3EB0D));
		do_reset(CFG_CPU, PPM_CPU);
		usb_suspend_in = 1'($urandom);
		usb_configured_in = 1'($urandom);
		b = 8'($urandom);
		usb_rx.push_back(b);
		u_ppm_host_model.access(1'b1, ADDR_DATA, 1'b0, 8'h00, r);
		check("flags", {rxf_n, txe_n}, 2'b00);
		rxq.push_back(b);
		u_ppm_host_model.access(1'b0, ADDR_DATA, 1'b0, 8'h00, r);
		check("flags", {rxf_n, txe_n}, 2'b10);
		u_ppm_host_model.access(1'b0, ADDR_STATUS, 1'b0, 8'h00, r);
		check("status", r, {4'h0, usb_configured_in, usb_suspend_in, 2'b10});
		b = 8'($urandom);
		txq.push_back(b);
		u_ppm_host_model.access(1'b0, ADDR_DATA, 1'b1, b, r);
		n = si_count;
		u_ppm_host_model.access(1'b0, ADDR_STATUS, 1'b1, 8'($urandom), r);
		check("send_immediate", 16'(si_count), 16'(n + 1));
		// bit-bang samples are free-running, not compared until sync mode
		tx_rand = 1'b1;
		tx_ignore = 1'b1;
		enumerated_in = 1'b0;
		command(CMD_ABB, PPM_CPU);
		enumerated_in = 1'b1;
		for (i = 0; i < 5; i++)
			command(cmd_tab[i], mode_tab[i]);
		b = 8'($urandom);
		rxq.push_back(b);
		usb_rx.push_back(b);
		rd_lo = 0;
		wr_lo = 0;
		repeat (4 * ABB_PERIOD_CYC) begin
			@(posedge sys_clk_in);
			#1;
			rd_lo += int'(rd_s === 1'b0);
			wr_lo += int'(wr_s === 1'b0);
		end
		check("abb_rd_pulses", 16'(rd_lo), 16'h0004);
		check("abb_wr_pulses", 16'(wr_lo), 16'h0004);
		check("abb_hold", {s_oe, dev_oe, dev_d}, {2'b11, b});
		command(CMD_SBB, PPM_SBB);
		for (i = 0; i < 60 && tx_valid !== 1'b0; i++)
			@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		tx_ignore = 1'b0;
		// pins still hold the async byte, so the first sample returns it
		txq.push_back(b);
		b = 8'($urandom);
		usb_rx.push_back(b);
		for (i = 0; i < 60 && rx_ready !== 1'b1; i++) begin
			@(posedge sys_clk_in);
			#1;
		end
		@(posedge sys_clk_in);
		for (i = 0; i < 5; i++) begin
			@(posedge sys_clk_in);
			#1;
			check("sbb_strobes", {rd_s, wr_s}, sbb_exp[9 - 2 * i -: 2]);
		end
		check("sbb_data", dev_d, b);
		for (i = 0; i < 60 && tx_valid !== 1'b0; i++)
			@(posedge sys_clk_in);
		repeat (10) @(posedge sys_clk_in);
		#1;
		check("sbb_idle", {tx_valid, dev_d}, {1'b0, b});
		check("sbb_returned", 16'(txq.size()), 16'h0000);
		do_reset(CFG_FSER, PPM_FSER);
		do_reset(CFG_UART, PPM_UART);
		do_reset(CFG_AFIFO, PPM_AFIFO);
		command(CMD_SFIFO, PPM_AFIFO);
		check("b_idle", b_oe, 1'b0);
		partner_afifo_in = 1'b1;
		command(CMD_SFIFO, PPM_SFIFO);
		check("buffer_merge", merge, 1'b1);
		check("b_default", {b_oe, b_soe, b_rxf, b_txe, b_d}, {4'b1010, PORT_IDLE});
		summarize();
	end
endmodule
`default_nettype wire
